// ==== core/sscc_cfg.svh ====
// constants for the strap sampling and clock configuration block
// assumes inclusion by sscc_pkg and sscc_top only
`ifndef SSCC_CFG_SVH
`define SSCC_CFG_SVH
`define SSCC_ADDR_CTRL 8'h00
`define SSCC_ADDR_STATUS 8'h04
`define SSCC_ADDR_PERIOD 8'h08
`define SSCC_ADDR_IRQ 8'h0C
`define SSCC_CTRL_FULL_BIT 0
`define SSCC_CTRL_RESET 1'h0
`define SSCC_STRAP_RESET 6'h00
`define SSCC_STRAP_FRAME_BIT 5
`define SSCC_STRAP_FWD_BIT 4
`define SSCC_OSC_NOMINAL 8'h20
`define SSCC_OSC_MIN 8'h02
`define SSCC_OSC_MAX 8'hFE
`define SSCC_RAMP_FIRST_LAST 4'hF
`define SSCC_RAMP_FULL_LAST 4'h0
`define SSCC_RATIO_DEFAULT 5'h08
`endif

// ==== core/sscc_pkg.sv ====
// types for the strap sampling and clock configuration block
// assumes sscc_cfg.svh is on the include path
package sscc_pkg;
`include "sscc_cfg.svh"
   // reset sequencer states, gray coded along settle -> nominal -> full
   typedef enum logic [1:0] {
      SSCC_SETTLE_WAIT_STATE = 2'h0,
      SSCC_NOMINAL_STATE = 2'h1,
      SSCC_FULL_STATE = 2'h3
   } sscc_state_t;

   // straps as latched from the interrupt pins
   typedef struct packed {
      logic frame_copy;
      logic fwd_internal;
      logic [3:0] ratio_code;
   } sscc_strap_t;

   // status word seen by software
   typedef struct packed {
      logic [12:0] zero;
      logic strap_bad;
      logic locked;
      logic fwd_reset;
      logic hold_reset;
      logic bypass;
      logic pump_en;
      logic [1:0] state;
      logic [4:0] ratio;
      sscc_strap_t strap;
   } sscc_status_t;
endpackage

// ==== core/sscc_top.sv ====
// strap capture at power-good, core clock source select and feedback divider
// assumes every pin input is asynchronous to pclk and slow against 25 MHz
// Operation
// - power_good_in rising latches the straps, including ratio_divisor.
// - power_good_in asserted enables the pll charge pump.
// - straps are taken at the power_good_in rising edge while reset is held.
// - after configuration the strap pins act as interrupt request inputs.
// - pll_skip_select 0 puts ref_clock_in on the core clock, 1 uses the pll.
// - in bypass divided_feedback_clock still follows the core clock.
// - strap bit 5 picks sampled frame_clock_in or a copy of feedback clock.
// - strap bit 4 picks which frame clock samples fwd_clock_reset_in.
// - strap bits 3..0 code ratio_divisor 3..16, 0000 meaning 8.
// - pll fully ramped aligns feedback clock rate to ref_clock_in.
// - in bypass feedback clock is ref_clock_in divided by ratio_divisor.
// - power_good_in low holds the sequencer idle and oscillator nominal.
// - before power_good_in the sequencer stays in settle_wait_state.
// - after power_good_in rises the pll locks against ref divided by 16.
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
module sscc_top
   import sscc_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // board pins
   input wire logic power_good_in,
   input wire logic system_reset_n,
   input wire logic pll_skip_select,
   input wire logic ref_clock_in,
   input wire logic frame_clock_in,
   input wire logic fwd_clock_reset_in,
   input wire logic [5:0] interrupt_strap_pins,
   // clocks out as one-cycle enables and levels
   output logic core_global_clock,
   output logic divided_feedback_clock,
   output logic frame_clock_int,
   // configuration results
   output logic pump_enable,
   output logic hold_reset,
   output logic fwd_reset_int,
   output logic [4:0] ratio_divisor,
   output logic [5:0] irq_request
);

   // maps a strap code to its divisor; illegal codes 0001 and 0010 give 8
   function automatic logic [4:0] ratio_of(input logic [3:0] code);
      logic [4:0] r;
      r = `SSCC_RATIO_DEFAULT;
      if (code >= 4'h3 && code <= 4'h7) begin
         r = {1'b0, code};
      end else if (code[3]) begin
         r = {1'b0, code} + 5'h01;
      end
      return r;
   endfunction

   function automatic logic code_bad(input logic [3:0] code);
      return code == 4'h1 || code == 4'h2;
   endfunction

   // two-flop synchronisers for every pin
   localparam int NSYNC = 13;
   logic [NSYNC-1:0] sync1;
   logic [NSYNC-1:0] sync2;
   logic [NSYNC-1:0] pins;
   assign pins = {power_good_in, system_reset_n, pll_skip_select, ref_clock_in,
                  frame_clock_in, fwd_clock_reset_in, interrupt_strap_pins, 1'b0};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1 <= '0;
         sync2 <= '0;
      end else begin
         sync1 <= pins;
         sync2 <= sync1;
      end
   end

   logic pg_s;
   logic sysrst_n_s;
   logic bypass_s;
   logic ref_s;
   logic frame_s;
   logic fwdrst_s;
   logic [5:0] strap_s;
   assign pg_s = sync2[12];
   assign sysrst_n_s = sync2[11];
   assign bypass_s = !sync2[10];
   assign ref_s = sync2[9];
   assign frame_s = sync2[8];
   assign fwdrst_s = sync2[7];
   assign strap_s = sync2[6:1];

   // edge detection on synchronised levels
   logic pg_d;
   logic ref_d;
   logic frame_d;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pg_d <= 1'b0;
         ref_d <= 1'b0;
         frame_d <= 1'b0;
      end else begin
         pg_d <= pg_s;
         ref_d <= ref_s;
         frame_d <= frame_s;
      end
   end

   logic pg_rise;
   logic ref_tick;
   logic frame_ext_tick;
   assign pg_rise = pg_s && !pg_d;
   assign ref_tick = ref_s && !ref_d;
   assign frame_ext_tick = frame_s && !frame_d;

   // software control
   logic ctrl_full;

   // reset sequencer
   sscc_state_t state;
   sscc_state_t next_state;
   always_comb begin
      next_state = state;
      unique case (state)
         SSCC_SETTLE_WAIT_STATE: begin
            if (pg_rise) begin
               next_state = SSCC_NOMINAL_STATE;
            end
         end
         SSCC_NOMINAL_STATE: begin
            if (ctrl_full && sysrst_n_s) begin
               next_state = SSCC_FULL_STATE;
            end
         end
         SSCC_FULL_STATE: begin
            if (!ctrl_full) begin
               next_state = SSCC_NOMINAL_STATE;
            end
         end
         default: begin
            next_state = SSCC_SETTLE_WAIT_STATE;
         end
      endcase
      if (!pg_s) begin
         next_state = SSCC_SETTLE_WAIT_STATE;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= SSCC_SETTLE_WAIT_STATE;
      end else begin
         state <= next_state;
      end
   end

   // strap latch, taken only at the power-good rising edge
   sscc_strap_t strap;
   logic strap_bad;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strap <= `SSCC_STRAP_RESET;
         ratio_divisor <= `SSCC_RATIO_DEFAULT;
         strap_bad <= 1'b0;
      end else if (pg_rise) begin
         strap <= strap_s;
         ratio_divisor <= ratio_of(strap_s[3:0]);
         strap_bad <= code_bad(strap_s[3:0]);
      end
   end

   // reset hold and charge pump
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pump_enable <= 1'b0;
         hold_reset <= 1'b1;
      end else begin
         pump_enable <= pg_s && state != SSCC_SETTLE_WAIT_STATE;
         hold_reset <= !pg_s || !sysrst_n_s;
      end
   end

   // pins serve as interrupt requests once configured
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_request <= '0;
      end else if (state != SSCC_SETTLE_WAIT_STATE && !pg_rise) begin
         irq_request <= strap_s;
      end else begin
         irq_request <= '0;
      end
   end

   // ref divided by the ramp divisor for the phase detector
   logic [3:0] ramp_last;
   logic [3:0] ref_cnt;
   logic ref_div_tick;
   assign ramp_last = (state == SSCC_FULL_STATE) ? `SSCC_RAMP_FULL_LAST
                                                 : `SSCC_RAMP_FIRST_LAST;
   assign ref_div_tick = ref_tick && ref_cnt >= ramp_last;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_cnt <= 4'h0;
      end else if (state == SSCC_SETTLE_WAIT_STATE) begin
         ref_cnt <= 4'h0;
      end else if (ref_tick) begin
         ref_cnt <= ref_div_tick ? 4'h0 : ref_cnt + 4'h1;
      end
   end

   // internal oscillator, period in pclk cycles
   logic [7:0] osc_period;
   logic [7:0] osc_cnt;
   logic osc_tick;
   assign osc_tick = osc_cnt >= osc_period - 8'h01;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_cnt <= 8'h00;
      end else begin
         osc_cnt <= osc_tick ? 8'h00 : osc_cnt + 8'h01;
      end
   end

   // core clock source select
   logic core_tick;
   assign core_tick = bypass_s ? ref_tick : osc_tick;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_global_clock <= 1'b0;
      end else begin
         core_global_clock <= core_tick;
      end
   end

   // feedback divider runs in both modes
   logic [4:0] fb_cnt;
   logic fb_tick;
   assign fb_tick = core_tick && fb_cnt >= ratio_divisor - 5'h01;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fb_cnt <= 5'h00;
         divided_feedback_clock <= 1'b0;
      end else if (core_tick) begin
         fb_cnt <= fb_tick ? 5'h00 : fb_cnt + 5'h01;
         divided_feedback_clock <= fb_tick || (fb_cnt + 5'h01) < (ratio_divisor >> 1);
      end
   end

   // phase detector and charge pump acting on the oscillator period
   logic signed [7:0] phase_err;
   logic locked;
   logic pll_active;
   assign pll_active = pump_enable && !bypass_s;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_err <= 8'sh00;
      end else if (!pll_active || ref_div_tick) begin
         phase_err <= 8'sh00;
      end else if (fb_tick && phase_err != 8'sh7F) begin
         phase_err <= phase_err + 8'sh01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_period <= `SSCC_OSC_NOMINAL;
         locked <= 1'b0;
      end else if (!pg_s) begin
         osc_period <= `SSCC_OSC_NOMINAL;
         locked <= 1'b0;
      end else if (pll_active && ref_div_tick) begin
         locked <= phase_err == 8'sh01;
         if (phase_err > 8'sh01 && osc_period != `SSCC_OSC_MAX) begin
            osc_period <= osc_period + 8'h01;
         end else if (phase_err < 8'sh01 && osc_period != `SSCC_OSC_MIN) begin
            osc_period <= osc_period - 8'h01;
         end
      end
   end

   // internal frame clock
   logic frame_int_tick;
   assign frame_int_tick = strap.frame_copy ? fb_tick : frame_ext_tick;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame_clock_int <= 1'b0;
      end else begin
         frame_clock_int <= frame_int_tick;
      end
   end

   // clock-forward reset sampled by the strapped frame clock
   logic fwd_sample;
   assign fwd_sample = strap.fwd_internal ? frame_int_tick : frame_ext_tick;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fwd_reset_int <= 1'b1;
      end else if (!pg_s) begin
         fwd_reset_int <= 1'b1;
      end else if (fwd_sample) begin
         fwd_reset_int <= fwdrst_s;
      end
   end

   // apb slave, zero wait states
   logic setup;
   logic wr_en;
   logic hit;
   assign setup = psel && !penable;
   assign wr_en = psel && penable && pwrite;
   assign pready = 1'b1;
   assign hit = paddr == `SSCC_ADDR_CTRL || paddr == `SSCC_ADDR_STATUS ||
                paddr == `SSCC_ADDR_PERIOD || paddr == `SSCC_ADDR_IRQ;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_full <= `SSCC_CTRL_RESET;
      end else if (wr_en && paddr == `SSCC_ADDR_CTRL) begin
         ctrl_full <= pwdata[`SSCC_CTRL_FULL_BIT];
      end
   end

   sscc_status_t status;
   always_comb begin
      status = '0;
      status.strap = strap;
      status.ratio = ratio_divisor;
      status.state = state;
      status.pump_en = pump_enable;
      status.bypass = bypass_s;
      status.hold_reset = hold_reset;
      status.fwd_reset = fwd_reset_int;
      status.locked = locked;
      status.strap_bad = strap_bad;
   end

   logic [31:0] next_prdata;
   always_comb begin
      next_prdata = 32'h0000_0000;
      unique case (paddr)
         `SSCC_ADDR_CTRL: next_prdata = {31'h0, ctrl_full};
         `SSCC_ADDR_STATUS: next_prdata = status;
         `SSCC_ADDR_PERIOD: next_prdata = {24'h0, osc_period};
         `SSCC_ADDR_IRQ: next_prdata = {26'h0, irq_request};
         default: next_prdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (setup) begin
         prdata <= pwrite ? 32'h0000_0000 : next_prdata;
         pslverr <= !hit;
      end
   end

endmodule

// ==== tb/sscc_assertions.sv ====
// concurrent checks on the pins and outputs of sscc_top
// assumes pin inputs change just after rising pclk edges
`timescale 1ns/10ps
module sscc_checker
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // board pins
   input wire logic power_good_in,
   input wire logic system_reset_n,
   input wire logic pll_skip_select,
   input wire logic ref_clock_in,
   input wire logic [5:0] interrupt_strap_pins,
   // outputs
   input wire logic core_global_clock,
   input wire logic pump_enable,
   input wire logic hold_reset,
   input wire logic fwd_reset_int,
   input wire logic [4:0] ratio_divisor,
   input wire logic [5:0] irq_request
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_ratio_range: assert property (ratio_divisor >= 5'h03 && ratio_divisor <= 5'h10)
      else $error("ratio divisor out of range");
   chk_pump_off: assert property (!power_good_in [*4] |=> !pump_enable)
      else $error("pump on without power good");
   chk_pump_on: assert property (power_good_in [*6] |-> pump_enable)
      else $error("pump not enabled");
   chk_hold_reset: assert property ((!system_reset_n || !power_good_in) [*4] |-> hold_reset)
      else $error("reset not held");
   chk_strap_hold: assert property (power_good_in [*8] |=> $stable(ratio_divisor))
      else $error("ratio changed without power good rise");
   chk_irq_follow: assert property ((power_good_in && $stable(interrupt_strap_pins)) [*8]
      |-> irq_request == interrupt_strap_pins)
      else $error("irq request does not follow pins");
   chk_core_idle: assert property ((!pll_skip_select && $stable(ref_clock_in)) [*5]
      |-> !core_global_clock)
      else $error("core tick without reference edge");
   chk_core_tick: assert property (!pll_skip_select [*4] ##0 $rose(ref_clock_in)
      |-> ##[2:4] core_global_clock)
      else $error("reference edge lost in bypass");
   chk_fwd_idle: assert property (!power_good_in [*4] |=> fwd_reset_int)
      else $error("forward reset released without power good");
endmodule
bind sscc_top sscc_checker u_chk (.*);

// ==== tb/sscc_board.sv ====
// board model: power good, system reset, reference clock and strap pulls
// assumes the bench gives requests just after rising pclk edges
`timescale 1ns/10ps
module sscc_board
#(parameter int HOLD = 64)
(
   // requests from the bench
   input wire logic pclk,
   input wire logic pg_req,
   input wire logic [5:0] strap_req,
   input wire logic frame_req,
   // pins toward the device
   output logic power_good_in,
   output logic system_reset_n,
   output logic ref_clock_in,
   output logic frame_clock_in,
   output logic [5:0] interrupt_strap_pins
);
   logic [1:0] ph;
   int held;
   initial begin
      ph = 2'h0;
      held = 0;
      power_good_in = 1'b0;
      system_reset_n = 1'b0;
      ref_clock_in = 1'b0;
      frame_clock_in = 1'b0;
      interrupt_strap_pins = 6'h00;
   end
   // reference runs free at one rate from time zero, frame clock follows the bench
   always @(posedge pclk) begin
      ph <= ph + 2'h1;
      if (ph == 2'h3) ref_clock_in <= ~ref_clock_in;
      power_good_in <= pg_req;
      frame_clock_in <= frame_req;
      held <= pg_req ? held + 1 : 0;
      system_reset_n <= pg_req && held >= HOLD;
      interrupt_strap_pins <= strap_req;
   end
endmodule

// ==== tb/test_strap_sampling_clock_config.sv ====
// self-checking bench for sscc_top with the board model on its pins
// assumes sscc_pkg, sscc_top, the checker and the board model compile first
`timescale 1ns/10ps
module test_strap_sampling_clock_config;
   import sscc_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic pll_skip_select = 1'b0;
   logic fwd_clock_reset_in = 1'b1;
   logic pg_req = 1'b0;
   logic [5:0] strap_req = 6'h00;
   logic frame_req = 1'b0;
   logic [31:0] prdata, seed = 32'h1055;
   logic pready, pslverr, power_good_in, system_reset_n, ref_clock_in, frame_clock_in;
   logic core_global_clock, divided_feedback_clock, frame_clock_int;
   logic pump_enable, hold_reset, fwd_reset_int;
   logic [5:0] interrupt_strap_pins, irq_request;
   logic [4:0] ratio_divisor;
   int err_count = 0, compares = 0, cycles = 0;
   always #20 pclk = ~pclk;
   sscc_board u_board (.pclk(pclk), .pg_req(pg_req), .strap_req(strap_req),
      .frame_req(frame_req),
      .power_good_in(power_good_in), .system_reset_n(system_reset_n),
      .ref_clock_in(ref_clock_in), .frame_clock_in(frame_clock_in),
      .interrupt_strap_pins(interrupt_strap_pins));
   sscc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .power_good_in(power_good_in), .system_reset_n(system_reset_n),
      .pll_skip_select(pll_skip_select), .ref_clock_in(ref_clock_in),
      .frame_clock_in(frame_clock_in), .fwd_clock_reset_in(fwd_clock_reset_in),
      .interrupt_strap_pins(interrupt_strap_pins), .core_global_clock(core_global_clock),
      .divided_feedback_clock(divided_feedback_clock), .frame_clock_int(frame_clock_int),
      .pump_enable(pump_enable), .hold_reset(hold_reset), .fwd_reset_int(fwd_reset_int),
      .ratio_divisor(ratio_divisor), .irq_request(irq_request));
   task report_and_stop();
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 60000) begin
         err_count++;
         report_and_stop();
      end
   end
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   function logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function logic [4:0] ratio_of(input logic [3:0] c);
      if (c < 4'h3) return 5'h08;
      if (c < 4'h8) return {1'b0, c};
      return {1'b0, c} + 5'h01;
   endfunction
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // core ticks and frame ticks over one whole feedback period
   task measure(output int ticks, output int frames);
      logic p, r;
      int n, k;
      for (k = 0; k < 2; k++) begin
         p = 1'b1;
         n = 0;
         ticks = 0;
         frames = 0;
         do begin
            @(negedge pclk);
            n++;
            ticks += int'(core_global_clock === 1'b1);
            frames += int'(frame_clock_int === 1'b1);
            r = divided_feedback_clock === 1'b1 && p === 1'b0;
            p = divided_feedback_clock;
         end while (!r && n < 600);
      end
   endtask
   initial begin
      logic [31:0] q;
      logic e;
      logic [5:0] s;
      int t, f, i;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      check("ratio_divisor", ratio_divisor, 32'h8);
      check("hold_reset", hold_reset, 32'h1);
      apb(1'b0, 8'h08, 32'h0, q, e);
      check("osc period", q, 32'h20);
      check("pready", pready, 32'h1);
      apb(1'b0, 8'h04, 32'h0, q, e);
      check("state", q[12:11], 32'h0);
      apb(1'b0, 8'h40, 32'h0, q, e);
      check("unmapped err", e, 32'h1);
      check("unmapped data", q, 32'h0);
      apb(1'b1, 8'h00, 32'h1, q, e);
      apb(1'b0, 8'h00, 32'h0, q, e);
      check("ctrl", q, 32'h1);
      fwd_clock_reset_in <= 1'b0;
      for (i = 0; i < 16; i++) begin
         @(posedge pclk);
         q = xs();
         s = {q[5:4], i[3:0]};
         pg_req <= 1'b0;
         repeat (8) @(posedge pclk);
         check("fwd idle", fwd_reset_int, 32'h1);
         check("pump idle", pump_enable, 32'h0);
         strap_req <= s;
         repeat (2) @(posedge pclk);
         pg_req <= 1'b1;
         repeat (8) @(posedge pclk);
         check("ratio", ratio_divisor, ratio_of(s[3:0]));
         check("pump", pump_enable, 32'h1);
         apb(1'b0, 8'h04, 32'h0, q, e);
         check("straps", q[5:0], s);
         check("strap bad", q[18], i == 1 || i == 2);
         check("state", q[12:11], 32'h1);
         strap_req <= ~s;
         repeat (8) @(posedge pclk);
         check("irq", irq_request, 6'(~s));
         check("ratio kept", ratio_divisor, ratio_of(s[3:0]));
         measure(t, f);
         check("core per fb", t, ratio_of(s[3:0]));
         check("frame ticks", f, s[5]);
         check("fwd reset", fwd_reset_int, !(s[4] && s[5]));
         // hold stays until the board releases system reset
         wait (system_reset_n === 1'b1);
         repeat (4) @(negedge pclk);
         check("hold released", hold_reset, 32'h0);
         apb(1'b0, 8'h04, 32'h0, q, e);
         check("full state", q[12:11], 32'h3);
         // one external frame edge samples the low forward reset on every path except strap bits 5 and 4 both set, where feedback ticks sample it
         frame_req <= 1'b1;
         repeat (8) @(posedge pclk);
         frame_req <= 1'b0;
         @(negedge pclk);
         check("fwd ext", fwd_reset_int, 32'h0);
      end
      @(posedge pclk);
      pg_req <= 1'b0;
      pll_skip_select <= 1'b1;
      repeat (8) @(posedge pclk);
      t = 0;
      repeat (320) begin
         @(negedge pclk);
         t += int'(core_global_clock === 1'b1);
      end
      check("pll ticks", t >= 9 && t <= 11, 32'h1);
      // with power good the loop must speed the slow nominal oscillator up
      @(posedge pclk);
      pg_req <= 1'b1;
      repeat (600) @(posedge pclk);
      @(negedge pclk);
      check("pump pll", pump_enable, 32'h1);
      apb(1'b0, 8'h08, 32'h0, q, e);
      check("osc faster", q < 32'h20, 32'h1);
      report_and_stop();
   end
endmodule
